// file: bench/dsf_assertions.sv
module dsf_assertions (
	input wire logic        clock,      // clock
	input wire logic        rst,        // reset
	input wire logic        req,        // strobe
	input wire logic        wr,         // write
	input wire logic [2:0]  sel,        // select
	input wire logic        chan,       // channel
	input wire logic        rvalid,     // answer
	input wire logic [15:0] rdata,      // read data
	input wire logic [1:0]  mode_code0, // mode one
	input wire logic [1:0]  mode_code1, // mode two
	input wire logic [15:0] filt_len0   // length one
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire rd = req && !wr;
	read_answer_a: assert property (rd |=> rvalid)
		else $error("read not answered");
	write_silent_a: assert property (req && wr |=> !rvalid)
		else $error("write answered");
	rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
		else $error("read data moved");
	len_forces_on_a: assert property (req && wr && sel == dsf_pkg::SEL_FILT_LEN && !chan
		|=> mode_code0 == dsf_pkg::MODE_CODE_ON) else $error("length write left mode");
	other_chan_kept_a: assert property (req && wr && !chan |=> $stable(mode_code1))
		else $error("channel two mode disturbed");
	mode_legal_a: assert property (mode_code0 != 2'h3)
		else $error("illegal mode");
	fixed_range_a: assert property (mode_code0 == dsf_pkg::MODE_CODE_ON && $past(mode_code0) == mode_code0
		|-> filt_len0 >= dsf_pkg::LEN_MIN && filt_len0 <= dsf_pkg::LEN_MAX) else $error("length out of range");
	unused_zero_a: assert property (rd && sel == dsf_pkg::SEL_COND |=> (rdata & 16'hD801) == 16'h0000)
		else $error("unused condition bit set");
	auto_read_a: assert property (rd && sel == dsf_pkg::SEL_FILT_LEN && !chan
		&& mode_code0 == dsf_pkg::MODE_CODE_AUTO |=> rdata == dsf_pkg::LEN_READ_AUTO) else $error("auto length read");
endmodule

bind dsf_top dsf_assertions u_chk (.clock, .rst, .req, .wr, .sel, .chan, .rvalid, .rdata, .mode_code0,
	.mode_code1, .filt_len0);

// file: bench/dsf_host.sv
module dsf_host (
	input  wire logic        clock,  // clock
	output logic             req,    // strobe
	output logic             wr,     // write
	output logic [2:0]       sel,    // select
	output logic             chan,   // channel
	output logic [15:0]      wdata,  // write data
	input  wire logic        rvalid, // answer
	input  wire logic [15:0] rdata   // read data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {req, wr, sel, chan, wdata} = '0;
	// released data bus shows the inverse of its last value
	task automatic access(input logic w, input logic [2:0] s, input logic c, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clock);
		#1 {req, wr, sel, chan, wdata} = {1'b1, w, s, c, d};
		@(posedge clock);
		#1 req = 1'b0;
		wdata = ~wdata;
		q = (rvalid === 1'b1) ? rdata : 'x;
	endtask
endmodule

// file: bench/test_device_status_and_filter_cfg.sv
module test_device_status_and_filter_cfg;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        req, wr, chan, rvalid, summary;
	logic        key = 1'b0;
	logic [2:0]  sel;
	logic [9:0]  v = '0;
	logic [15:0] wdata, rdata, q, fl0, fl1;
	logic [15:0] level = 16'h1000;
	logic [1:0]  mc0, mc1;
	int          mismatches = 0;
	int          tests_run = 0;
	always #2 clock = ~clock;
	dsf_top uut (.clock, .rst, .req, .wr, .sel, .chan, .wdata, .sensor_on(v[1:0]), .chan_fault(v[3:2]),
		.cal_shape(v[5:4]), .cal_smart(v[7:6]), .cal_auto(v[9:8]), .key_press(key), .level_ch0(level),
		.level_ch1(~level), .rvalid, .rdata, .summary, .mode_code0(mc0), .mode_code1(mc1), .filt_len0(fl0),
		.filt_len1(fl1));
	dsf_host host (.clock, .req, .wr, .sel, .chan, .wdata, .rvalid, .rdata);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [2:0] s, input logic c, input logic [15:0] d);
		host.access(1'b1, s, c, d, q);
	endtask
	task automatic get(input string what, input logic [2:0] s, input logic c, input logic [15:0] exp);
		host.access(1'b0, s, c, 16'h0000, q);
		check(what, q, exp);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		end_sim();
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		get("mask", dsf_pkg::SEL_MASK, 1'b0, 16'h0000);
		get("rising", dsf_pkg::SEL_PTRANS, 1'b0, 16'h0000);
		get("falling", dsf_pkg::SEL_NTRANS, 1'b0, 16'h0000);
		get("event", dsf_pkg::SEL_EVENT, 1'b0, 16'h0000);
		get("off len", dsf_pkg::SEL_FILT_LEN, 1'b0, dsf_pkg::LEN_READ_OFF);
		check("summary", 16'(summary), 16'h0000);
		$display("reset test done");
		put(dsf_pkg::SEL_FILT_LEN, 1'b0, 16'h0064);
		get("len one", dsf_pkg::SEL_FILT_LEN, 1'b0, 16'h0064);
		check("mode one", 16'(mc0), 16'(dsf_pkg::MODE_CODE_ON));
		check("mode two", 16'(mc1), 16'(dsf_pkg::MODE_CODE_OFF));
		get("len two", dsf_pkg::SEL_FILT_LEN, 1'b1, dsf_pkg::LEN_READ_OFF);
		put(dsf_pkg::SEL_FILT_MODE, 1'b0, 16'(dsf_pkg::MODE_CODE_AUTO));
		get("auto len", dsf_pkg::SEL_FILT_LEN, 1'b0, dsf_pkg::LEN_READ_AUTO);
		repeat (3) @(posedge clock);
		check("auto applied", fl0, dsf_pkg::LEN_MAX - (level >> 4));
		put(dsf_pkg::SEL_FILT_LEN, 1'b1, 16'h0001);
		get("short", dsf_pkg::SEL_FILT_LEN, 1'b1, dsf_pkg::LEN_MIN);
		put(dsf_pkg::SEL_FILT_LEN, 1'b1, 16'h0BB8);
		get("long", dsf_pkg::SEL_FILT_LEN, 1'b1, dsf_pkg::LEN_MAX);
		check("mode two on", 16'(mc1), 16'(dsf_pkg::MODE_CODE_ON));
		check("applied two", fl1, dsf_pkg::LEN_MAX);
		put(dsf_pkg::SEL_FILT_MODE, 1'b0, 16'(dsf_pkg::MODE_CODE_OFF));
		get("off again", dsf_pkg::SEL_FILT_LEN, 1'b0, dsf_pkg::LEN_READ_OFF);
		$display("filter test done");
		for (int i = 0; i < 11; i++) begin
			{key, v} = 11'h001 << i;
			repeat (5) @(posedge clock);
			get("condition", dsf_pkg::SEL_COND, 1'b0, {2'h0, key, 2'h0, v, 1'b0});
		end
		$display("condition test done");
		{key, v} = '0;
		put(dsf_pkg::SEL_PTRANS, 1'b0, 16'hFFFF);
		put(dsf_pkg::SEL_MASK, 1'b0, 16'h0002);
		get("mask", dsf_pkg::SEL_MASK, 1'b0, 16'h0002);
		repeat (6) @(posedge clock);
		check("summary idle", 16'(summary), 16'h0000);
		{key, v} = 11'h7FF;
		repeat (6) @(posedge clock);
		check("summary set", 16'(summary), 16'h0001);
		get("rise event", dsf_pkg::SEL_EVENT, 1'b0, 16'h27FE);
		get("cleared", dsf_pkg::SEL_EVENT, 1'b0, 16'h0000);
		repeat (2) @(posedge clock);
		check("summary clear", 16'(summary), 16'h0000);
		put(dsf_pkg::SEL_PTRANS, 1'b0, 16'h0000);
		put(dsf_pkg::SEL_NTRANS, 1'b0, 16'hFFFF);
		{key, v} = '0;
		repeat (6) @(posedge clock);
		get("fall event", dsf_pkg::SEL_EVENT, 1'b0, 16'h27FE);
		$display("event test done");
		end_sim();
	end
endmodule

// file: hdl/dsf_pkg.sv
package dsf_pkg;

	// ----------------------------------------
	// register selects for the command port
	// ----------------------------------------
	localparam logic [2:0] SEL_FILT_MODE = 3'h0;
	localparam logic [2:0] SEL_FILT_LEN  = 3'h1;
	localparam logic [2:0] SEL_COND      = 3'h2;
	localparam logic [2:0] SEL_MASK      = 3'h3;
	localparam logic [2:0] SEL_EVENT     = 3'h4;
	localparam logic [2:0] SEL_PTRANS    = 3'h5;
	localparam logic [2:0] SEL_NTRANS    = 3'h6;

	// ----------------------------------------
	// filter modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		DSF_OFF  = 3'h1,
		DSF_ON   = 3'h2,
		DSF_AUTO = 3'h4
	} dsf_mode_e;

	localparam logic [1:0] MODE_CODE_OFF  = 2'h0;
	localparam logic [1:0] MODE_CODE_ON   = 2'h1;
	localparam logic [1:0] MODE_CODE_AUTO = 2'h2;

	// ----------------------------------------
	// filter length, in 10 ms units as an unsigned count
	// ----------------------------------------
	localparam int          LEN_STEP_MS  = 50;
	localparam int          LEN_MIN_MS   = 50;
	localparam int          LEN_MAX_MS   = 20000;
	localparam int          LEN_UNIT_MS  = 10;
	localparam logic [15:0] LEN_MIN      = 16'(LEN_MIN_MS / LEN_UNIT_MS);
	localparam logic [15:0] LEN_MAX      = 16'(LEN_MAX_MS / LEN_UNIT_MS);
	localparam logic [15:0] LEN_RESET    = LEN_MIN;
	localparam logic [15:0] LEN_READ_AUTO = 16'hFFFF;
	localparam logic [15:0] LEN_READ_OFF  = 16'h0000;

	// ----------------------------------------
	// condition word bit positions
	// ----------------------------------------
	localparam int BIT_CONN1  = 1;
	localparam int BIT_CONN2  = 2;
	localparam int BIT_ERR1   = 3;
	localparam int BIT_ERR2   = 4;
	localparam int BIT_SHAPE1 = 5;
	localparam int BIT_SHAPE2 = 6;
	localparam int BIT_SMART1 = 7;
	localparam int BIT_SMART2 = 8;
	localparam int BIT_ACAL1  = 9;
	localparam int BIT_ACAL2  = 10;
	localparam int BIT_KEY    = 13;

	localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

// file: hdl/dsf_top.sv
module dsf_top (
	input  wire logic        clock,        // 250 MHz clock
	input  wire logic        rst,          // synchronous reset, active high
	input  wire logic        req,          // register access strobe, one cycle
	input  wire logic        wr,           // 1 write, 0 read
	input  wire logic [2:0]  sel,          // register select
	input  wire logic        chan,         // channel suffix: 0 first, 1 second
	input  wire logic [15:0] wdata,        // write data
	input  wire logic [1:0]  sensor_on,    // sensor attached, per channel
	input  wire logic [1:0]  chan_fault,   // channel fault, per channel
	input  wire logic [1:0]  cal_shape,    // shape calibration table in use
	input  wire logic [1:0]  cal_smart,    // sensor-stored calibration table in use
	input  wire logic [1:0]  cal_auto,     // automatic calibration table in use
	input  wire logic        key_press,    // front-panel key press seen
	input  wire logic [15:0] level_ch0,    // present signal level, channel one
	input  wire logic [15:0] level_ch1,    // present signal level, channel two
	output logic             rvalid,       // read data valid, one cycle
	output logic [15:0]      rdata,        // read data
	output logic             summary,      // device summary indication
	output logic [1:0]       mode_code0,   // channel one mode code
	output logic [1:0]       mode_code1,   // channel two mode code
	output logic [15:0]      filt_len0,    // channel one applied length, 10 ms units
	output logic [15:0]      filt_len1     // channel two applied length, 10 ms units
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]              sens_a;
		logic [1:0]              sens_b;
		logic [8:0]              sync_a;
		logic [8:0]              sync_b;
		logic [1:0][1:0]         code;
		dsf_pkg::dsf_mode_e [1:0] mode;
		logic [1:0][15:0]        len;
		logic [1:0][15:0]        applied;
		logic [15:0]             cond;
		logic [15:0]             mask;
		logic [15:0]             event_w;
		logic [15:0]             ptrans;
		logic [15:0]             ntrans;
		logic                    rvalid;
		logic [15:0]             rdata;
		logic                    summary;
	} dsf_state_s;

	dsf_state_s st;
	dsf_state_s next_st;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] dsf_clamp(input logic [15:0] v);
		if (v < dsf_pkg::LEN_MIN)
			return dsf_pkg::LEN_MIN;
		else if (v > dsf_pkg::LEN_MAX)
			return dsf_pkg::LEN_MAX;
		else
			return v;
	endfunction

	function automatic logic [1:0] dsf_code(input dsf_pkg::dsf_mode_e m);
		case (m)
			dsf_pkg::DSF_ON:   return dsf_pkg::MODE_CODE_ON;
			dsf_pkg::DSF_AUTO: return dsf_pkg::MODE_CODE_AUTO;
			default:           return dsf_pkg::MODE_CODE_OFF;
		endcase
	endfunction

	// larger signal needs less integration: length shrinks to LEN_MIN as level rises, then jumps to LEN_MAX once lvl[15:4] exceeds LEN_MAX
	function automatic logic [15:0] dsf_auto_len(input logic [15:0] lvl);
		return dsf_clamp(dsf_pkg::LEN_MAX - {4'h0, lvl[15:4]});
	endfunction

	function automatic logic [15:0] dsf_applied(input dsf_pkg::dsf_mode_e m,
		input logic [15:0] l, input logic [15:0] lvl);
		case (m)
			dsf_pkg::DSF_ON:   return l;
			dsf_pkg::DSF_AUTO: return dsf_auto_len(lvl);
			default:           return dsf_pkg::LEN_READ_OFF;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [8:0]  live;
	logic [15:0] new_cond;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [1:0]  ci;
	logic        rd_req;
	logic        wr_req;

	always_comb begin
		next_st = st;
		live = {key_press, cal_auto, cal_smart, cal_shape, chan_fault};
		ci = {1'b0, chan};
		rd_req = req && !wr;
		wr_req = req && wr;

		// two flip-flops on every asynchronous level before the condition word
		next_st.sens_a = sensor_on;
		next_st.sens_b = st.sens_a;
		next_st.sync_a = live;
		next_st.sync_b = st.sync_a;

		// condition word follows the synchronised live inputs
		new_cond = dsf_pkg::WORD_RESET;
		new_cond[dsf_pkg::BIT_CONN1]  = st.sens_b[0];
		new_cond[dsf_pkg::BIT_CONN2]  = st.sens_b[1];
		new_cond[dsf_pkg::BIT_ERR1]   = st.sync_b[0];
		new_cond[dsf_pkg::BIT_ERR2]   = st.sync_b[1];
		new_cond[dsf_pkg::BIT_SHAPE1] = st.sync_b[2];
		new_cond[dsf_pkg::BIT_SHAPE2] = st.sync_b[3];
		new_cond[dsf_pkg::BIT_SMART1] = st.sync_b[4];
		new_cond[dsf_pkg::BIT_SMART2] = st.sync_b[5];
		new_cond[dsf_pkg::BIT_ACAL1]  = st.sync_b[6];
		new_cond[dsf_pkg::BIT_ACAL2]  = st.sync_b[7];
		new_cond[dsf_pkg::BIT_KEY]    = st.sync_b[8];
		next_st.cond = new_cond;

		rise = ~st.cond & new_cond & st.ptrans;
		fall = st.cond & ~new_cond & st.ntrans;

		next_st.rvalid = 1'b0;
		next_st.rdata = st.rdata;

		// ----------------------------------------
		// event word: a transition in the clearing cycle survives
		// ----------------------------------------
		if (rd_req && (sel == dsf_pkg::SEL_EVENT)) begin
			next_st.event_w = rise | fall;
		end else begin
			next_st.event_w = st.event_w | rise | fall;
		end

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (wr_req) begin
			case (sel)
				dsf_pkg::SEL_FILT_MODE: begin
					case (wdata[1:0])
						dsf_pkg::MODE_CODE_ON:   next_st.mode[ci] = dsf_pkg::DSF_ON;
						dsf_pkg::MODE_CODE_AUTO: next_st.mode[ci] = dsf_pkg::DSF_AUTO;
						default:                 next_st.mode[ci] = dsf_pkg::DSF_OFF;
					endcase
				end
				dsf_pkg::SEL_FILT_LEN: begin
					next_st.len[ci] = dsf_clamp(wdata);
					next_st.mode[ci] = dsf_pkg::DSF_ON;
				end
				dsf_pkg::SEL_MASK:   next_st.mask = wdata;
				dsf_pkg::SEL_PTRANS: next_st.ptrans = wdata;
				dsf_pkg::SEL_NTRANS: next_st.ntrans = wdata;
				default: ;
			endcase
		end else if (rd_req) begin
			// ----------------------------------------
			// register reads, answered one cycle later
			// ----------------------------------------
			next_st.rvalid = 1'b1;
			case (sel)
				dsf_pkg::SEL_FILT_MODE: next_st.rdata = {14'h0000, dsf_code(st.mode[ci])};
				dsf_pkg::SEL_FILT_LEN: begin
					case (st.mode[ci])
						dsf_pkg::DSF_AUTO: next_st.rdata = dsf_pkg::LEN_READ_AUTO;
						dsf_pkg::DSF_ON:   next_st.rdata = st.len[ci];
						default:           next_st.rdata = dsf_pkg::LEN_READ_OFF;
					endcase
				end
				dsf_pkg::SEL_COND:   next_st.rdata = st.cond;
				dsf_pkg::SEL_MASK:   next_st.rdata = st.mask;
				dsf_pkg::SEL_EVENT:  next_st.rdata = st.event_w;
				dsf_pkg::SEL_PTRANS: next_st.rdata = st.ptrans;
				dsf_pkg::SEL_NTRANS: next_st.rdata = st.ntrans;
				default:             next_st.rdata = dsf_pkg::WORD_RESET;
			endcase
		end

		// ----------------------------------------
		// applied lengths and mode codes
		// ----------------------------------------
		// the applied length follows the mode one cycle late, so for one cycle after a
		// mode change the mode code output is new while the length is still the old one
		next_st.applied[0] = dsf_applied(st.mode[0], st.len[0], level_ch0);
		next_st.applied[1] = dsf_applied(st.mode[1], st.len[1], level_ch1);

		// mode codes registered so that the outputs come from flip-flops
		next_st.code[0] = dsf_code(next_st.mode[0]);
		next_st.code[1] = dsf_code(next_st.mode[1]);

		// ----------------------------------------
		// summary indication
		// ----------------------------------------
		next_st.summary = |(st.mask & st.event_w);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			st.sens_a  <= '0;
			st.sens_b  <= '0;
			st.sync_a  <= '0;
			st.sync_b  <= '0;
			st.code    <= '{dsf_pkg::MODE_CODE_OFF, dsf_pkg::MODE_CODE_OFF};
			st.mode    <= '{dsf_pkg::DSF_OFF, dsf_pkg::DSF_OFF};
			st.len     <= '{dsf_pkg::LEN_RESET, dsf_pkg::LEN_RESET};
			st.applied <= '0;
			st.cond    <= dsf_pkg::WORD_RESET;
			st.mask    <= dsf_pkg::WORD_RESET;
			st.event_w <= dsf_pkg::WORD_RESET;
			st.ptrans  <= dsf_pkg::WORD_RESET;
			st.ntrans  <= dsf_pkg::WORD_RESET;
			st.rvalid  <= 1'b0;
			st.rdata   <= dsf_pkg::WORD_RESET;
			st.summary <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every output is a plain flip-flop of the state record
	assign rvalid     = st.rvalid;
	assign rdata      = st.rdata;
	assign summary    = st.summary;
	assign mode_code0 = st.code[0];
	assign mode_code1 = st.code[1];
	assign filt_len0  = st.applied[0];
	assign filt_len1  = st.applied[1];

endmodule
